// *** verilog/rbps_seq.sv ***
// rectifier bus power sequencer with axi4-lite register slave
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
// Contract
// - bypass switch open at power-up
// - doubler strap open at power-up
// - initially converters disabled, bus good high
// - no doubling while bus above 200 V
// - on settle, bypass only above 235 V
// - enable converters 150 ms after bypass
// - assert bus good 150 ms after enable
// - drop bus good below 205 V
// - disable converters below 190 V
// - power back after disable reruns sequence
// - power back before disable rides through
// - enable output high means converters on
// - above 400 V disable and open bypass
// - below 180 V open bypass
module rbps_seq
#(
	parameter int STEP_N = rbps_pkg::STEP_CYC // cycles per power-up step
)
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire rbps_pkg::rbps_cmp_t i_cmp,
	input wire logic i_settled,
	output logic o_bypass_close,
	output logic o_strap_close,
	output logic o_conv_enable,
	output logic o_bus_good_flag_b,
	output logic o_irq,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready
);
	import rbps_pkg::*;

	rbps_state_t state_r; // sequencer state
	rbps_state_t state_nxt; // next sequencer state
	logic [CNT_W-1:0] cnt_r; // step delay counter
	logic cnt_done; // step delay elapsed
	logic [31:0] ctrl_r; // control register, bit 0 run
	logic [EV_N-1:0] ist_r; // sticky events
	logic [EV_N-1:0] msk_r; // event mask
	logic [EV_N-1:0] ev; // event pulses this cycle
	logic aw_hold_r; // write address taken
	logic w_hold_r; // write data taken
	logic [7:0] awaddr_r; // latched write address
	logic [31:0] wdata_r; // latched write data
	logic [3:0] wstrb_r; // latched strobes
	logic wr_go; // both halves present
	logic run; // sequencer allowed to start
	logic [31:0] msk_wr; // mask word after byte strobes

	// merge write data under byte strobes
	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (st[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		end
		return res;
	endfunction

	assign run = ctrl_r[0];
	assign cnt_done = (cnt_r == CNT_W'(STEP_N - 1));
	assign msk_wr = strb_merge({25'h0, msk_r}, wdata_r, wstrb_r);

	// sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_INIT:
			begin
				// settle with enough bus closes bypass
				if (run && i_settled && i_cmp.above_235 && !i_cmp.above_400)
					state_nxt = ST_BYPASS;
			end
			ST_BYPASS:
			begin
				if (i_cmp.above_400 || !i_cmp.above_180)
					state_nxt = ST_INIT;
				else if (cnt_done)
					state_nxt = ST_ENABLED;
			end
			ST_ENABLED:
			begin
				if (i_cmp.above_400 || !i_cmp.above_190)
					state_nxt = ST_OFF;
				else if (!i_cmp.above_205)
					state_nxt = ST_FALL;
				else if (cnt_done)
					state_nxt = ST_RUN;
			end
			ST_RUN:
			begin
				if (i_cmp.above_400 || !i_cmp.above_190)
					state_nxt = ST_OFF;
				else if (!i_cmp.above_205)
					state_nxt = ST_FALL;
			end
			ST_FALL:
			begin
				// ride through: power back before disable level
				if (i_cmp.above_400 || !i_cmp.above_190)
					state_nxt = ST_OFF;
				else if (i_cmp.above_235)
					state_nxt = ST_RUN;
			end
			ST_OFF:
			begin
				// full rerun from the initial state
				state_nxt = ST_INIT;
			end
			default:
				state_nxt = ST_INIT;
		endcase
	end

	// state register
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			state_r <= ST_INIT;
		else
			state_r <= state_nxt;
	end

	// step counter, restarts on each state change
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b || state_r == ST_INIT || state_nxt != state_r)
			cnt_r <= '0;
		else if (!cnt_done)
			cnt_r <= cnt_r + CNT_W'(1);
	end

	// bypass switch and converter enable
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			o_bypass_close <= 1'b0;
			o_conv_enable <= 1'b0;
		end
		else
		begin
			o_bypass_close <= (state_nxt != ST_INIT) && (state_nxt != ST_OFF);
			o_conv_enable <= (state_nxt == ST_ENABLED) || (state_nxt == ST_RUN)
				|| (state_nxt == ST_FALL);
		end
	end

	// bus good flag, active low
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			o_bus_good_flag_b <= 1'b1;
		else
			o_bus_good_flag_b <= (state_nxt != ST_RUN);
	end

	// doubler strap: chosen once charging settles, dropped on rerun
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			o_strap_close <= 1'b0;
		else if (state_r == ST_INIT && i_cmp.above_200)
			o_strap_close <= 1'b0;
		else if (state_r == ST_INIT && run && i_settled && !i_cmp.above_200)
			o_strap_close <= 1'b1;
		else if (state_r == ST_OFF)
			o_strap_close <= 1'b0;
	end

	// event pulses
	always_comb
	begin
		ev = '0;
		ev[EV_BYPASS] = (state_r == ST_INIT) && (state_nxt == ST_BYPASS);
		ev[EV_ENABLE] = (state_r == ST_BYPASS) && (state_nxt == ST_ENABLED);
		ev[EV_GOOD] = (state_r != ST_RUN) && (state_nxt == ST_RUN);
		ev[EV_WARN] = (state_nxt == ST_FALL) && (state_r != ST_FALL);
		ev[EV_OFF] = (state_nxt == ST_OFF);
		ev[EV_OV] = i_cmp.above_400 && (state_r != ST_INIT) && (state_r != ST_OFF);
		ev[EV_UV] = (state_r == ST_BYPASS) && !i_cmp.above_180;
	end

	// axi write channel capture
	assign wr_go = aw_hold_r && w_hold_r && !o_bvalid;
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OK;
		end
		else
		begin
			if (i_awvalid && o_awready)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= i_awaddr;
			end
			if (i_wvalid && o_wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= i_wdata;
				wstrb_r <= i_wstrb;
			end
			if (wr_go)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= (awaddr_r == OFF_CTRL || awaddr_r == OFF_IRQ_ST
					|| awaddr_r == OFF_IRQ_MSK) ? RESP_OK : RESP_SLVERR;
			end
			else if (o_bvalid && i_bready)
				o_bvalid <= 1'b0;
		end
	end

	// ready while the slot is free
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			o_awready <= 1'b0;
			o_wready <= 1'b0;
		end
		else
		begin
			o_awready <= !aw_hold_r && !(i_awvalid && o_awready);
			o_wready <= !w_hold_r && !(i_wvalid && o_wready);
		end
	end

	// writable registers; hardware set wins over clear
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			ctrl_r <= CTRL_RST;
			msk_r <= MSK_RST[EV_N-1:0];
			ist_r <= '0;
		end
		else
		begin
			if (wr_go && awaddr_r == OFF_CTRL)
				ctrl_r <= strb_merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_0001;
			if (wr_go && awaddr_r == OFF_IRQ_MSK)
				msk_r <= msk_wr[EV_N-1:0];
			if (wr_go && awaddr_r == OFF_IRQ_ST)
				ist_r <= (ist_r & ~(wdata_r[EV_N-1:0] & {EV_N{wstrb_r[0]}})) | ev;
			else
				ist_r <= ist_r | ev;
		end
	end

	// interrupt output
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			o_irq <= 1'b0;
		else
			o_irq <= |(((ist_r | ev)) & msk_r);
	end

	// axi read channel
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= RESP_OK;
		end
		else
		begin
			o_arready <= !o_rvalid && !(i_arvalid && o_arready);
			if (i_arvalid && o_arready)
			begin
				o_rvalid <= 1'b1;
				o_rresp <= RESP_OK;
				case (i_araddr)
					OFF_CTRL: o_rdata <= ctrl_r;
					OFF_STAT: o_rdata <= {22'h0, state_r, o_bus_good_flag_b, o_conv_enable,
						o_strap_close, o_bypass_close};
					OFF_IRQ_ST: o_rdata <= {25'h0, ist_r};
					OFF_IRQ_MSK: o_rdata <= {25'h0, msk_r};
					default:
					begin
						o_rdata <= 32'h0000_0000;
						o_rresp <= RESP_SLVERR;
					end
				endcase
			end
			else if (o_rvalid && i_rready)
				o_rvalid <= 1'b0;
		end
	end

	// checks
	chk_init_outputs: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		state_r == ST_INIT |-> !o_conv_enable && o_bus_good_flag_b)
		else $error("outputs not idle in init");
	chk_strap_high_bus: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		state_r == ST_INIT && i_cmp.above_200 |=> !o_strap_close)
		else $error("strap closed above 200 V");
	chk_bypass_level: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(o_bypass_close) |-> $past(i_cmp.above_235))
		else $error("bypass closed at low bus");
	chk_enable_delay: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(o_conv_enable) |-> cnt_r == '0 && $past(cnt_done))
		else $error("enable without full delay");
	chk_good_drop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		!o_bus_good_flag_b && !i_cmp.above_205 |=> o_bus_good_flag_b)
		else $error("bus good held below 205 V");
	chk_disable_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_conv_enable && !i_cmp.above_190 |=> !o_conv_enable)
		else $error("converters on below 190 V");
	chk_ov_trip: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_cmp.above_400 |=> !o_conv_enable && !o_bypass_close)
		else $error("no overvoltage trip");
	chk_fault_open: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		state_r == ST_BYPASS && !i_cmp.above_180 |=> !o_bypass_close)
		else $error("bypass held below 180 V");
	chk_off_rerun: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		state_r == ST_OFF |=> state_r == ST_INIT ##1 !o_conv_enable)
		else $error("no rerun after disable");
	cov_full_up: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		$fell(o_bus_good_flag_b));
	cov_ride: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		state_r == ST_FALL ##1 state_r == ST_RUN);
	cov_doubler: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		$rose(o_strap_close));
	cov_irq: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) $rose(o_irq));
endmodule

// *** verilog/rbps_pkg.sv ***
// package: constants and carrier types for the rectifier bus power sequencer
package rbps_pkg;
	// clock and timing
	localparam int CLK_HZ = 10000000; // system clock rate
	localparam int STEP_MS = 150; // delay between power-up steps, in ms
	localparam int STEP_CYC = (CLK_HZ / 1000) * STEP_MS; // cycles per step
	localparam int CNT_W = 24; // step counter width
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00; // control
	localparam logic [7:0] OFF_STAT = 8'h04; // live state
	localparam logic [7:0] OFF_IRQ_ST = 8'h08; // sticky events
	localparam logic [7:0] OFF_IRQ_MSK = 8'h0C; // event mask
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0001; // sequencer enabled
	localparam logic [31:0] MSK_RST = 32'h0000_0000; // all masked
	// event bit positions
	localparam int EV_BYPASS = 0; // bypass closed
	localparam int EV_ENABLE = 1; // converters enabled
	localparam int EV_GOOD = 2; // bus good asserted
	localparam int EV_WARN = 3; // bus good dropped
	localparam int EV_OFF = 4; // converters disabled
	localparam int EV_OV = 5; // overvoltage trip
	localparam int EV_UV = 6; // fault undervoltage trip
	localparam int EV_N = 7; // number of events
	// axi responses
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// comparator inputs, each high while the bus is above its level
	typedef struct packed {
		logic above_400; // overvoltage level
		logic above_235; // bypass and good level
		logic above_205; // bus good falloff
		logic above_200; // doubler decision
		logic above_190; // converter disable
		logic above_180; // fault level
	} rbps_cmp_t;
	// sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_INIT = 6'h01, // charging through thermistor
		ST_BYPASS = 6'h02, // bypass closed, waiting to enable
		ST_ENABLED = 6'h04, // converters on, waiting for good
		ST_RUN = 6'h08, // fully up
		ST_FALL = 6'h10, // bus good dropped, riding through
		ST_OFF = 6'h20 // converters disabled, wait for rerun
	} rbps_state_t;
endpackage

// *** sim/rbps_bus_model.sv ***
// bus model: turns a bus voltage into the comparator levels
`timescale 1ns/100ps
module rbps_bus_model
(
	input wire logic [9:0] i_volts,
	output rbps_pkg::rbps_cmp_t o_cmp
);
	import rbps_pkg::*;
	// each level high while the bus is strictly above it, msb first
	assign o_cmp = {i_volts > 10'h190, i_volts > 10'h0EB, i_volts > 10'h0CD,
		i_volts > 10'h0C8, i_volts > 10'h0BE, i_volts > 10'h0B4};
endmodule

// *** sim/tb_rbps_seq.sv ***
// testbench for the rectifier bus power sequencer
`timescale 1ns/100ps
module tb_rbps_seq;
	import rbps_pkg::*;
	localparam int STEP_T = 1000; // shortened power-up step for the bench
	localparam int LIMIT = 10 * STEP_T; // all steps plus margin
	logic clk; // system clock
	logic rst_b; // sync reset, active low
	logic [9:0] volts; // bus voltage seen by the model
	logic settled; // charging slope near zero
	rbps_cmp_t cmp; // comparator levels
	logic byp, strap, en, good_b, irq; // sequencer outputs
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int err_total; // mismatches
	int check_count; // comparisons
	int cyc; // cycle counter for the timeout
	int k; // measured delay
	int t_en; // cycle stamp of converter enable
	rbps_bus_model rbps_bus_model_inst (.i_volts(volts), .o_cmp(cmp));
	rbps_seq #(.STEP_N(STEP_T)) rbps_seq_inst (.i_sys_clk(clk), .i_rst_b(rst_b), .i_cmp(cmp),
		.i_settled(settled), .o_bypass_close(byp), .o_strap_close(strap),
		.o_conv_enable(en), .o_bus_good_flag_b(good_b), .o_irq(irq),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
	// free running clock, 100 ns period
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// verdict and end of run
	task automatic end_sim();
		if (err_total == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			err_total++;
			end_sim();
		end
	end
	// one comparison, reported on mismatch
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp)
		begin
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
			err_total++;
		end
	endtask
	// axi write: address and data together, each released when taken
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, r}, "write response");
	endtask
	// axi read with data and response check
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		chk(rdata, d, "read data");
		chk({30'h0, rresp}, {30'h0, r}, "read response");
	endtask
	// count edges until an output reaches a level: 0 bypass, 1 enable, 2 good_b
	task automatic wait_lvl(input int sel, input logic v, output int n);
		logic s;
		n = 0;
		s = ~v;
		while (s !== v)
		begin
			@(posedge clk);
			n++;
			s = (sel == 0) ? byp : (sel == 1) ? en : good_b;
		end
	endtask
	// set the bus, let the outputs settle
	task automatic bus(input logic [9:0] v);
		volts <= v;
		repeat (4) @(posedge clk);
	endtask
	// main sequence
	initial
	begin
		{err_total, check_count} = '0;
		{rst_b, settled, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		volts = 10'h0;
		repeat (16) @(posedge clk);
		chk({27'h0, byp, strap, en, good_b, irq}, 32'h2, "reset outputs");
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		rd_chk(OFF_CTRL, CTRL_RST, RESP_OK);
		rd_chk(OFF_IRQ_MSK, MSK_RST, RESP_OK);
		rd_chk(8'h10, 32'h0, RESP_SLVERR);
		wr_chk(OFF_STAT, 32'hF, RESP_SLVERR);
		wr_chk(OFF_IRQ_MSK, 32'h7F, RESP_OK);
		settled <= 1'b1;
		bus(10'h0D2);
		chk({30'h0, strap, byp}, 32'h0, "settled at 210 V");
		bus(10'h096);
		chk({30'h0, strap, byp}, 32'h2, "settled at 150 V");
		volts <= 10'h12C;
		wait_lvl(0, 1'b1, k);
		chk(32'(k < 4), 32'h1, "bypass latency");
		wait_lvl(1, 1'b1, k);
		t_en = cyc;
		chk(32'(k > STEP_T - 4 && k < STEP_T + 4), 32'h1, "enable delay");
		chk({31'h0, strap}, 32'h0, "strap open above 200 V");
		rd_chk(OFF_IRQ_ST, 32'h3, RESP_OK);
		chk({31'h0, irq}, 32'h1, "irq raised");
		wr_chk(OFF_IRQ_ST, 32'h7F, RESP_OK);
		rd_chk(OFF_IRQ_ST, 32'h0, RESP_OK);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		wait_lvl(2, 1'b0, k);
		k = cyc - t_en;
		chk(32'(k > STEP_T - 4 && k < STEP_T + 4), 32'h1, "good delay");
		bus(10'h0C8);
		chk({29'h0, byp, en, good_b}, 32'h7, "ride through at 200 V");
		bus(10'h12C);
		chk({29'h0, byp, en, good_b}, 32'h6, "power back");
		rd_chk(OFF_STAT, 32'h85, RESP_OK);
		bus(10'h0B9);
		chk({31'h0, en}, 32'h0, "disable below 190 V");
		rd_chk(OFF_IRQ_ST, 32'h1C, RESP_OK);
		wr_chk(OFF_IRQ_MSK, 32'h0, RESP_OK);
		rd_chk(OFF_IRQ_MSK, 32'h0, RESP_OK);
		chk({31'h0, irq}, 32'h0, "irq masked");
		wr_chk(OFF_IRQ_ST, 32'h7F, RESP_OK);
		volts <= 10'h12C;
		wait_lvl(0, 1'b1, k);
		chk({31'h0, en}, 32'h0, "rerun starts disabled");
		bus(10'h0AA);
		chk({31'h0, byp}, 32'h0, "fault below 180 V");
		rd_chk(OFF_IRQ_ST, 32'h41, RESP_OK);
		volts <= 10'h12C;
		wait_lvl(0, 1'b1, k);
		bus(10'h19A);
		chk({30'h0, byp, en}, 32'h0, "overvoltage");
		wr_chk(OFF_CTRL, 32'h0, RESP_OK);
		bus(10'h12C);
		repeat (8) @(posedge clk);
		chk({31'h0, byp}, 32'h0, "start refused when stopped");
		wr_chk(OFF_CTRL, 32'h1, RESP_OK);
		wait_lvl(0, 1'b1, k);
		end_sim();
	end
endmodule
